// file: rtcc_pkg.sv
// constants shared by the real-time clock control block
`default_nettype none
package rtcc_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ADDR_CTRL1 = 3'h0;
  localparam logic [2:0] ADDR_EVT_EN = 3'h1;
  localparam logic [2:0] ADDR_CSEL = 3'h2;
  localparam logic [2:0] ADDR_FLAGS = 3'h3;
  localparam logic [2:0] ADDR_SECONDS = 3'h4;
  localparam logic [2:0] ADDR_HOURS = 3'h5;
  // clock_run_format_control fields
  localparam int RUN_BIT = 7;
  localparam int FMT24_BIT = 6;
  localparam int PM_BIT = 5;
  localparam int SRST_BIT = 4;
  localparam logic [7:0] CTRL1_WMASK = 8'hF0;
  localparam logic [7:0] CTRL1_SRST_MASK = 8'h10;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] EVT_EN_RESET = 8'h00;
  // clock_source_select fields
  localparam int OSEL_LSB = 4;
  localparam logic [7:0] CSEL_WMASK = 8'h7F;
  localparam logic [7:0] CSEL_RESET = 8'h08;
  localparam logic [3:0] SRC_WATCH = 4'h8;
  // event positions, shared by enable and flag registers
  localparam int EV_OVF = 7;
  localparam int EV_WEEK = 6;
  localparam int EV_DAY = 5;
  localparam int EV_HOUR = 4;
  localparam int EV_MIN = 3;
  localparam int EV_SEC = 2;
  localparam int EV_HALF = 1;
  localparam int EV_QTR = 0;
  // calendar limits
  localparam logic [1:0] WATCH_DIV_LAST = 2'h3;
  localparam logic [5:0] SEC_LAST = 6'd59;
  localparam logic [5:0] MIN_LAST = 6'd59;
  localparam logic [4:0] HR12_LAST = 5'd11;
  localparam logic [4:0] HR24_LAST = 5'd23;
  localparam logic [2:0] WDAY_LAST = 3'd6;
  localparam logic [7:0] FRC_LAST = 8'hFF;
  // quarter second in watch-clock/4 ticks
  localparam int QTR_DIV_DEFAULT = 2048;

  // last prescaler count for each free-running source
  function automatic logic [12:0] frc_div_last(input logic [3:0] sel);
    case (sel)
      4'h0: frc_div_last = 13'h0007;
      4'h1: frc_div_last = 13'h001F;
      4'h2: frc_div_last = 13'h007F;
      4'h3: frc_div_last = 13'h00FF;
      4'h4: frc_div_last = 13'h01FF;
      4'h5: frc_div_last = 13'h07FF;
      4'h6: frc_div_last = 13'h0FFF;
      default: frc_div_last = 13'h1FFF;
    endcase
  endfunction
endpackage
`default_nettype wire

// file: rtcc_top.sv
// real-time clock control, clock select and event flags
//
// How it works
// - run bit 7 of control 1 stops counting at 0, runs at 1.
// - hour-format bit 0 gives 12-hour mode, hours count 0 to 11.
// - hour-format bit 1 gives 24-hour mode, hours count 0 to 23.
// - in 12-hour mode bit 5 reads 0 mornings, 1 afternoons.
// - soft-reset bit 4 holds everything in reset except clock select, the clock output divider and itself.
// - bits 3 to 0 of control 1 always read 0.
// - an enabled periodic event sets its flag in the event flag register.
// - enable register bits 7..0: overflow, week, day, hour, minute, 1s, 0.5s, 0.25s.
// - overflow enable works only in free-running mode; overflow raises its event.
// - any source but watch/4 turns the unit into an 8-bit free-running counter.
// - run bit starts and stops the free-running counter too.
// - in free-running mode the seconds register reads the counter.
// - source codes 0000..0111 pick system clock /8,/32,/128,/256,/512,/2048,/4096,/8192.
// - source code 1000 selects watch clock /4 and calendar mode; reset value.
// - output select: 000 /4, 010 /8, 100 /16, xx1 watch clock, when pin enabled.
// - divided system clock is output only in active or sleep mode.
// - bit 7 of clock select always reads 0.
// - flags never clear by themselves; software writes 0 to clear one.
// - the weekly event occurs when the day-of-week count reaches 0.
`timescale 1ns/100ps
`default_nettype none
module rtcc_top #(
  parameter int QTR_DIV = rtcc_pkg::QTR_DIV_DEFAULT
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic WATCH_TICK,
  input wire logic PORT_MODE_CLKOUT,
  input wire logic ACTIVE_OR_SLEEP,
  output logic CLOCK_OUTPUT_PIN,
  output logic [7:0] EVENT_FLAGS
);
  import rtcc_pkg::*;

  localparam logic [10:0] QTR_LAST = 11'(QTR_DIV - 1);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] ctrl1_reg, ctrl1_next;
  logic [7:0] evt_en_reg, evt_en_next;
  logic [7:0] csel_reg, csel_next;
  logic [7:0] flags_reg, flags_next;
  logic [1:0] wdiv_reg, wdiv_next;
  logic [10:0] qcnt_reg, qcnt_next;
  logic [1:0] qphase_reg, qphase_next;
  logic [5:0] sec_reg, sec_next;
  logic [5:0] min_reg, min_next;
  logic [4:0] hour_reg, hour_next;
  logic [2:0] wday_reg, wday_next;
  logic [12:0] pdiv_reg, pdiv_next;
  logic [7:0] frc_reg, frc_next;
  logic [4:0] odiv_reg, odiv_next;
  logic wlvl_reg, wlvl_next;
  logic pin_reg, pin_next;
  logic [7:0] rdata_reg, rdata_next;

  logic srst, run, fmt24, rtc_mode, pm_flip;
  logic [7:0] ev_vec;
  logic [2:0] osel;
  logic wr_ctrl1, wr_evt_en, wr_csel, wr_flags;

  // decoded controls
  assign srst = ctrl1_reg[SRST_BIT];
  assign run = ctrl1_reg[RUN_BIT];
  assign fmt24 = ctrl1_reg[FMT24_BIT];
  assign rtc_mode = (csel_reg[3:0] == SRC_WATCH);
  assign osel = csel_reg[OSEL_LSB+2:OSEL_LSB];

  // address decode for writes
  always_comb begin
    wr_ctrl1 = 1'b0;
    wr_evt_en = 1'b0;
    wr_csel = 1'b0;
    wr_flags = 1'b0;
    if (REG_WR && REG_ADDR == ADDR_CTRL1) begin
      wr_ctrl1 = 1'b1;
    end else if (REG_WR && REG_ADDR == ADDR_EVT_EN) begin
      wr_evt_en = 1'b1;
    end else if (REG_WR && REG_ADDR == ADDR_CSEL) begin
      wr_csel = 1'b1;
    end else if (REG_WR && REG_ADDR == ADDR_FLAGS) begin
      wr_flags = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timekeeping and free-running counter next state
  always_comb begin
    wdiv_next = wdiv_reg;
    qcnt_next = qcnt_reg;
    qphase_next = qphase_reg;
    sec_next = sec_reg;
    min_next = min_reg;
    hour_next = hour_reg;
    wday_next = wday_reg;
    pdiv_next = pdiv_reg;
    frc_next = frc_reg;
    ev_vec = 8'h00;
    pm_flip = 1'b0;
    if (srst) begin
      wdiv_next = '0;
      qcnt_next = '0;
      qphase_next = '0;
      sec_next = '0;
      min_next = '0;
      hour_next = '0;
      wday_next = '0;
      pdiv_next = '0;
      frc_next = '0;
    // calendar advances only while running; watch/4
    end else if (rtc_mode && run && WATCH_TICK) begin
      wdiv_next = wdiv_reg + 2'h1;
      if (wdiv_reg == WATCH_DIV_LAST && qcnt_reg == QTR_LAST) begin
        qcnt_next = '0;
        qphase_next = qphase_reg + 2'h1;
        ev_vec[EV_QTR] = 1'b1;
        ev_vec[EV_HALF] = qphase_reg[0];
        ev_vec[EV_SEC] = (qphase_reg == 2'h3);
      end else if (wdiv_reg == WATCH_DIV_LAST) begin
        qcnt_next = qcnt_reg + 11'h001;
      end
      if (ev_vec[EV_SEC]) begin
        sec_next = (sec_reg >= SEC_LAST) ? 6'h00 : sec_reg + 6'h01;
        ev_vec[EV_MIN] = (sec_reg >= SEC_LAST);
      end
      if (ev_vec[EV_MIN]) begin
        min_next = (min_reg >= MIN_LAST) ? 6'h00 : min_reg + 6'h01;
        ev_vec[EV_HOUR] = (min_reg >= MIN_LAST);
      end
      if (ev_vec[EV_HOUR]) begin
        if (fmt24) begin
          hour_next = (hour_reg >= HR24_LAST) ? 5'h00 : hour_reg + 5'h01;
          ev_vec[EV_DAY] = (hour_reg >= HR24_LAST);
        end else begin
          hour_next = (hour_reg >= HR12_LAST) ? 5'h00 : hour_reg + 5'h01;
          pm_flip = (hour_reg >= HR12_LAST);
          ev_vec[EV_DAY] = pm_flip && ctrl1_reg[PM_BIT];
        end
      end
      if (ev_vec[EV_DAY]) begin
        wday_next = (wday_reg >= WDAY_LAST) ? 3'h0 : wday_reg + 3'h1;
        ev_vec[EV_WEEK] = (wday_reg >= WDAY_LAST);
      end
    // counter runs only with run bit; prescaler
    end else if (!rtc_mode && run) begin
      if (pdiv_reg >= frc_div_last(csel_reg[3:0])) begin
        pdiv_next = '0;
        frc_next = frc_reg + 8'h01;
        ev_vec[EV_OVF] = (frc_reg == FRC_LAST);
      end else begin
        pdiv_next = pdiv_reg + 13'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers next state
  always_comb begin
    ctrl1_next = ctrl1_reg;
    evt_en_next = evt_en_reg;
    csel_next = csel_reg;
    flags_next = flags_reg;
    // bit 7 of clock select never stored
    if (wr_csel) begin
      csel_next = REG_WDATA & CSEL_WMASK;
    end
    // only soft-reset survives; software clears it
    if (srst) begin
      ctrl1_next = (wr_ctrl1 ? REG_WDATA : ctrl1_reg) & CTRL1_SRST_MASK;
      evt_en_next = EVT_EN_RESET;
      flags_next = 8'h00;
    end else begin
      if (wr_ctrl1) begin
        ctrl1_next = REG_WDATA & CTRL1_WMASK;
      end else if (pm_flip) begin
        ctrl1_next[PM_BIT] = ~ctrl1_reg[PM_BIT];
      end
      if (wr_evt_en) begin
        evt_en_next = REG_WDATA;
      end
      // written zeros clear, nothing else does
      if (wr_flags) begin
        flags_next = flags_reg & REG_WDATA;
      end
      // enabled events set flags, set wins over clear
      flags_next = flags_next | (ev_vec & evt_en_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock output and read data next state
  always_comb begin
    odiv_next = odiv_reg + 5'h01;
    wlvl_next = WATCH_TICK ? ~wlvl_reg : wlvl_reg;
    pin_next = 1'b0;
    rdata_next = 8'h00;
    // pin enabled by port mode; xx1 follows watch clock
    if (!PORT_MODE_CLKOUT) begin
      pin_next = 1'b0;
    end else if (osel[0]) begin
      pin_next = wlvl_reg;
    // divided clock only in active or sleep
    end else if (ACTIVE_OR_SLEEP) begin
      case (osel[2:1])
        2'h0: pin_next = odiv_reg[1];
        2'h1: pin_next = odiv_reg[2];
        2'h2: pin_next = odiv_reg[3];
        default: pin_next = odiv_reg[4];
      endcase
    end
    // register reads, unmapped give zero
    if (REG_RD) begin
      if (REG_ADDR == ADDR_CTRL1) begin
        rdata_next = ctrl1_reg & CTRL1_WMASK;
      end else if (REG_ADDR == ADDR_EVT_EN) begin
        rdata_next = evt_en_reg;
      end else if (REG_ADDR == ADDR_CSEL) begin
        rdata_next = csel_reg & CSEL_WMASK;
      end else if (REG_ADDR == ADDR_FLAGS) begin
        rdata_next = flags_reg;
      end else if (REG_ADDR == ADDR_SECONDS) begin
        rdata_next = rtc_mode ? {2'b00, sec_reg} : frc_reg;
      end else if (REG_ADDR == ADDR_HOURS) begin
        rdata_next = {3'b000, hour_reg};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; calendar values are held through a system reset only
  // by software, so they all start from zero here
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl1_reg <= CTRL1_RESET;
      evt_en_reg <= EVT_EN_RESET;
      csel_reg <= CSEL_RESET;
      flags_reg <= 8'h00;
      wdiv_reg <= '0;
      qcnt_reg <= '0;
      qphase_reg <= '0;
      sec_reg <= '0;
      min_reg <= '0;
      hour_reg <= '0;
      wday_reg <= '0;
      pdiv_reg <= '0;
      frc_reg <= '0;
      odiv_reg <= '0;
      wlvl_reg <= 1'b0;
      pin_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ctrl1_reg <= ctrl1_next;
      evt_en_reg <= evt_en_next;
      csel_reg <= csel_next;
      flags_reg <= flags_next;
      wdiv_reg <= wdiv_next;
      qcnt_reg <= qcnt_next;
      qphase_reg <= qphase_next;
      sec_reg <= sec_next;
      min_reg <= min_next;
      hour_reg <= hour_next;
      wday_reg <= wday_next;
      pdiv_reg <= pdiv_next;
      frc_reg <= frc_next;
      odiv_reg <= odiv_next;
      wlvl_reg <= wlvl_next;
      pin_reg <= pin_next;
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from flip-flops
  assign REG_RDATA = rdata_reg;
  assign CLOCK_OUTPUT_PIN = pin_reg;
  assign EVENT_FLAGS = flags_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence frc_wrap_s;
    !srst && !rtc_mode && run && frc_reg == FRC_LAST
      && pdiv_reg >= frc_div_last(csel_reg[3:0]);
  endsequence

  sequence day_wrap_s;
    ev_vec[EV_DAY] && wday_reg == WDAY_LAST;
  endsequence

  chk_stop_holds_time: assert property (!run |=> $stable(sec_reg) && $stable(frc_reg))
    else $error("counting while stopped");
  // prescaler moves while running; judged one cycle on, so a later stop is no miss
  chk_frc_runs: assert property (!srst && !rtc_mode && run |=> $changed(pdiv_reg))
    else $error("free-running prescaler stuck");
  chk_hour_12h: assert property (
      !fmt24 && !$past(fmt24) && $past(hour_reg) <= HR12_LAST |-> hour_reg <= HR12_LAST)
    else $error("hour out of 12-hour range");
  chk_hour_24h: assert property (hour_reg <= HR24_LAST)
    else $error("hour out of 24-hour range");
  chk_pm_flip: assert property (
      pm_flip && !wr_ctrl1
      |=> ctrl1_reg[PM_BIT] != $past(ctrl1_reg[PM_BIT]) && hour_reg == 5'h00)
    else $error("half-day indicator did not flip at wrap");
  chk_srst_hold: assert property (
      srst |=> evt_en_reg == 8'h00 && flags_reg == 8'h00 && frc_reg == 8'h00
      && ($stable(csel_reg) || $past(wr_csel)))
    else $error("soft reset did not hold state");
  chk_ctrl1_rsvd: assert property (
      REG_RD && REG_ADDR == ADDR_CTRL1 |=> REG_RDATA[3:0] == 4'h0)
    else $error("reserved control bits read nonzero");
  chk_flag_set: assert property (
      !srst && |(ev_vec & evt_en_reg)
      |=> (flags_reg & $past(ev_vec & evt_en_reg)) == $past(ev_vec & evt_en_reg))
    else $error("enabled event did not set its flag");
  chk_ovf_event: assert property (
      frc_wrap_s ##0 evt_en_reg[EV_OVF] |=> flags_reg[EV_OVF] && frc_reg == 8'h00)
    else $error("overflow flag not raised");
  chk_sec_readback: assert property (
      REG_RD && REG_ADDR == ADDR_SECONDS && !rtc_mode |=> REG_RDATA == $past(frc_reg))
    else $error("seconds read is not the counter");
  chk_csel_rsvd: assert property (REG_RD && REG_ADDR == ADDR_CSEL |=> !REG_RDATA[7])
    else $error("clock select bit 7 read as one");
  chk_clkout_idle: assert property (!ACTIVE_OR_SLEEP && !osel[0] |=> !CLOCK_OUTPUT_PIN)
    else $error("divided clock out of active or sleep");
  chk_no_autoclear: assert property (
      !wr_flags && !srst |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
    else $error("flag cleared without a write");
  chk_week_event: assert property (day_wrap_s |-> ev_vec[EV_WEEK] ##1 wday_reg == 3'h0)
    else $error("week event not at day zero");
endmodule // rtcc_top
`default_nettype wire

// file: tb_rtcc_top.sv
// self-checking testbench for the real-time clock control block
`timescale 1ns/100ps
`default_nettype none
module tb_rtcc_top;
  import rtcc_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic watch_tick = 1'b0;
  logic port_mode_clkout = 1'b0;
  logic active_or_sleep = 1'b1;
  logic clock_output_pin;
  logic [7:0] event_flags;
  int bad_count = 0;
  int comparisons = 0;
  int toggles = 0;
  logic last_pin = 1'b0;
  logic [7:0] v1;
  logic [7:0] v2;
  int div;

  ////////////////////////////////////////////////////////////////////////////
  // small quarter-second length keeps calendar runs short
  rtcc_top #(.QTR_DIV(2)) rtcc_top_inst (
    .CLK(clk),
    .SYS_RST(sys_rst),
    .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr),
    .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata),
    .WATCH_TICK(watch_tick),
    .PORT_MODE_CLKOUT(port_mode_clkout),
    .ACTIVE_OR_SLEEP(active_or_sleep),
    .CLOCK_OUTPUT_PIN(clock_output_pin),
    .EVENT_FLAGS(event_flags)
  );

  // 50 ns period
  always #25 clk = ~clk;

  // count pin toggles; compared on edges so a stuck pin shows as zero
  always @(posedge clk) begin
    if (clock_output_pin !== last_pin) toggles++;
    last_pin = clock_output_pin;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic rdchk(input string what, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(what, d, exp);
  endtask

  // one watch pulse every four system cycles
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      watch_tick <= 1'b1;
      @(posedge clk);
      watch_tick <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(negedge clk);
  endtask

  function automatic logic [7:0] inside_rng(input logic [7:0] v, input int lo, input int hi);
    return (int'(v) >= lo && int'(v) <= hi) ? 8'h01 : 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // watchdog sized well above the roughly 35k-cycle sequence
  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    $display("BAD watchdog expected end seen hang");
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values and reserved bits
    rdchk("ctrl1", ADDR_CTRL1, 8'h00);
    @(negedge clk);
    check("rdata idle", reg_rdata, 8'h00);
    rdchk("evt_en", ADDR_EVT_EN, 8'h00);
    rdchk("csel", ADDR_CSEL, 8'h08);
    rdchk("unmapped", 3'h6, 8'h00);
    wr(ADDR_CTRL1, 8'h67);
    rdchk("ctrl1 low", ADDR_CTRL1, 8'h60);
    wr(ADDR_CSEL, 8'hF8);
    rdchk("csel top", ADDR_CSEL, 8'h78);
    wr(ADDR_CSEL, 8'h08);
    wr(ADDR_EVT_EN, 8'hFF);
    rdchk("evt_en all", ADDR_EVT_EN, 8'hFF);
    // calendar events: quarter every 8 pulses, half 16, second 32
    wr(ADDR_CTRL1, 8'hC0);
    ticks(7);
    check("flags 7", event_flags, 8'h00);
    ticks(1);
    check("flags 8", event_flags, 8'h01);
    ticks(8);
    check("flags 16", event_flags, 8'h03);
    ticks(16);
    check("flags 32", event_flags, 8'h07);
    rdchk("seconds", ADDR_SECONDS, 8'h01);
    // writing 1 keeps a flag, 0 clears it; nothing clears itself
    wr(ADDR_FLAGS, 8'h06);
    repeat (20) @(negedge clk);
    check("flags keep", event_flags, 8'h06);
    // run bit low stops timekeeping
    wr(ADDR_CTRL1, 8'h40);
    wr(ADDR_FLAGS, 8'h00);
    ticks(40);
    check("flags stopped", event_flags, 8'h00);
    rdchk("seconds stopped", ADDR_SECONDS, 8'h01);
    // disabled events and overflow enable in calendar mode set nothing
    wr(ADDR_EVT_EN, 8'h80);
    wr(ADDR_CTRL1, 8'hC0);
    ticks(40);
    check("flags masked", event_flags, 8'h00);
    // free-running counter at every source rate, read back via seconds
    wr(ADDR_EVT_EN, 8'h00);
    for (int s = 0; s < 8; s++) begin
      div = (s == 0) ? 8 : (s == 1) ? 32 : (s == 2) ? 128 : (s == 3) ? 256 :
            (s == 4) ? 512 : (s == 5) ? 2048 : (s == 6) ? 4096 : 8192;
      wr(ADDR_CSEL, {4'h0, 4'(s)});
      rd(ADDR_SECONDS, v1);
      repeat (2 * div - 2) @(posedge clk);
      rd(ADDR_SECONDS, v2);
      check("frc step", inside_rng(v2 - v1, 1, 3), 8'h01);
    end
    check("flags frc", event_flags, 8'h00);
    // run bit also freezes the counter
    wr(ADDR_CSEL, 8'h00);
    wr(ADDR_CTRL1, 8'h40);
    rd(ADDR_SECONDS, v1);
    repeat (40) @(posedge clk);
    rdchk("frc held", ADDR_SECONDS, v1);
    // a full wrap of the 8-bit counter raises only the overflow flag
    wr(ADDR_EVT_EN, 8'h80);
    wr(ADDR_CTRL1, 8'hC0);
    repeat (256 * 8 + 16) @(negedge clk);
    check("flags ovf", event_flags, 8'h80);
    // soft reset clears all but clock select, the clock output divider and itself
    wr(ADDR_EVT_EN, 8'hFF);
    wr(ADDR_CSEL, 8'h25);
    wr(ADDR_CTRL1, 8'hF0);
    rdchk("ctrl1 srst", ADDR_CTRL1, 8'h10);
    wr(ADDR_EVT_EN, 8'h0F);
    rdchk("evt_en srst", ADDR_EVT_EN, 8'h00);
    check("flags srst", event_flags, 8'h00);
    rdchk("csel srst", ADDR_CSEL, 8'h25);
    wr(ADDR_CTRL1, 8'h00);
    rdchk("ctrl1 out", ADDR_CTRL1, 8'h00);
    // clock output: divided system clock and the watch clock
    @(posedge clk);
    port_mode_clkout <= 1'b1;
    for (int o = 0; o < 4; o++) begin
      wr(ADDR_CSEL, {1'b0, 3'(2 * o), 4'h8});
      repeat (4) @(negedge clk);
      toggles = 0;
      repeat (64) @(negedge clk);
      check("clkout div", inside_rng(8'(toggles), (32 >> o) - 1, (32 >> o) + 1), 8'h01);
    end
    check("clkout 32", inside_rng(8'(toggles), 3, 5), 8'h01);
    wr(ADDR_CSEL, 8'h18);
    // clear away from the edge so the toggle counter does not race it
    @(negedge clk);
    toggles = 0;
    ticks(8);
    check("clkout watch", inside_rng(8'(toggles), 7, 9), 8'h01);
    wr(ADDR_CSEL, 8'h08);
    active_or_sleep <= 1'b0;
    repeat (4) @(negedge clk);
    toggles = 0;
    repeat (32) @(negedge clk);
    check("clkout standby", {7'h00, clock_output_pin} | 8'(toggles), 8'h00);
    @(posedge clk);
    active_or_sleep <= 1'b1;
    port_mode_clkout <= 1'b0;
    repeat (4) @(negedge clk);
    toggles = 0;
    repeat (32) @(negedge clk);
    check("clkout off", {7'h00, clock_output_pin} | 8'(toggles), 8'h00);
    end_of_test();
  end
endmodule // tb_rtcc_top
`default_nettype wire
